/* src/fobs_fast_ocp.sv */
// fast overcurrent slice: scale registers, blanking, debounce and pwm shutdown
`timescale 1ns/1ps
module fobs_fast_ocp
    import fobs_pkg::*;
#(
    parameter int PWM_N = 4
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic [15:0] reg_addr_in,
    input wire logic reg_wr_en_in,
    input wire logic [15:0] reg_wr_data_in,
    output logic [15:0] reg_rd_data_out,
    input wire logic [2:0] current_limit_threshold_in,
    input wire logic cs_over_pos_in,
    input wire logic cs_over_neg_in,
    input wire logic pwm_on_start_in,
    input wire logic cycle_start_in,
    input wire logic [PWM_N-1:0] pwm_in,
    output logic [PWM_N-1:0] pwm_out,
    output logic fast_ocp_trip_out,
    output fobs_vin_scale_t input_voltage_scale_out,
    output fobs_iin_gain_t input_current_sense_gain_out
);
    // ****************************************
    // reset release
    // ****************************************
    logic rst_meta_r;
    logic rst_n_r;

    // async assert, two-flop release so all flops leave reset on one edge
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    fobs_ocp_timing_t timing_r;
    logic [15:0] rd_nxt;

    // writes store only the writable bits
    always_ff @(posedge mclk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            input_voltage_scale_out <= FOBS_RST_VIN_SCALE;
            input_current_sense_gain_out <= FOBS_RST_IIN_GAIN;
            timing_r <= FOBS_RST_OCP_TIMING;
        end else if (reg_wr_en_in) begin
            if (reg_addr_in == FOBS_ADDR_VIN_SCALE) begin
                input_voltage_scale_out <= reg_wr_data_in & FOBS_MASK_VIN_SCALE;
            end
            if (reg_addr_in == FOBS_ADDR_IIN_GAIN) begin
                input_current_sense_gain_out <= reg_wr_data_in & FOBS_MASK_IIN_GAIN;
            end
            if (reg_addr_in == FOBS_ADDR_OCP_TIMING) begin
                timing_r <= reg_wr_data_in & FOBS_MASK_OCP_TIMING;
            end
        end
    end

    // read mux, unmapped addresses read zero
    always_comb begin
        unique case (reg_addr_in)
            FOBS_ADDR_VIN_SCALE: rd_nxt = input_voltage_scale_out;
            FOBS_ADDR_IIN_GAIN: rd_nxt = input_current_sense_gain_out;
            FOBS_ADDR_OCP_TIMING: rd_nxt = timing_r;
            default: rd_nxt = FOBS_RD_ZERO;
        endcase
    end

    // registered read data, one cycle after the address
    always_ff @(posedge mclk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            reg_rd_data_out <= FOBS_RD_ZERO;
        end else begin
            reg_rd_data_out <= rd_nxt;
        end
    end

    // ****************************************
    // timing decode
    // ****************************************
    logic [FOBS_CNT_W-1:0] deb_limit;
    logic [FOBS_CNT_W-1:0] blank_limit;

    // times become cycle counts at the core clock rate
    always_comb begin
        deb_limit = fobs_ns_to_cyc(FOBS_DEB_NS[timing_r.debounce]);
        blank_limit = fobs_ns_to_cyc(FOBS_BLANK_NS[timing_r.blank]);
    end

    // ****************************************
    // comparator, blanking and debounce
    // ****************************************
    logic cmp_act_r;
    logic blank_done;
    logic blanking;
    logic qual;
    logic deb_done;
    logic trip_set;

    // polarity choice registered with the sample to keep the path short
    always_ff @(posedge mclk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            cmp_act_r <= 1'b0;
        end else if ((current_limit_threshold_in & FOBS_THR_NEG_BIT) != 3'h0) begin
            cmp_act_r <= cs_over_neg_in;
        end else begin
            cmp_act_r <= cs_over_pos_in;
        end
    end

    // blanking restarts on every on-time start
    fobs_span_counter #(.W(FOBS_CNT_W)) u_blank (
        .clk_in(mclk_in),
        .rst_n_in(rst_n_r),
        .clr_in(pwm_on_start_in),
        .limit_in(blank_limit),
        .done_out(blank_done)
    );

    // comparator is masked while blanking so switching spikes never count
    assign blanking = !blank_done;
    assign qual = cmp_act_r && !blanking;

    // any drop of the qualified comparator restarts the debounce run
    fobs_span_counter #(.W(FOBS_CNT_W)) u_debounce (
        .clk_in(mclk_in),
        .rst_n_in(rst_n_r),
        .clr_in(!qual),
        .limit_in(deb_limit),
        .done_out(deb_done)
    );

    assign trip_set = deb_done && qual;

    // ****************************************
    // pwm shutdown
    // ****************************************
    // a trip in the cycle-start cycle wins so it is never lost
    always_ff @(posedge mclk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            fast_ocp_trip_out <= 1'b0;
        end else if (trip_set) begin
            fast_ocp_trip_out <= 1'b1;
        end else if (cycle_start_in) begin
            fast_ocp_trip_out <= 1'b0;
        end
    end

    // outputs are gated from the trip cycle itself, one flop of latency
    always_ff @(posedge mclk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            pwm_out <= '0;
        end else if (trip_set || fast_ocp_trip_out) begin
            pwm_out <= '0;
        end else begin
            pwm_out <= pwm_in;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    vin_write_a: assert property (@(posedge mclk_in) disable iff (!rst_n_r)
        reg_wr_en_in && reg_addr_in == FOBS_ADDR_VIN_SCALE |=>
        input_voltage_scale_out == ($past(reg_wr_data_in) & FOBS_MASK_VIN_SCALE))
        else $error("input voltage scale write wrong");
    gain_write_a: assert property (@(posedge mclk_in) disable iff (!rst_n_r)
        reg_wr_en_in && reg_addr_in == FOBS_ADDR_IIN_GAIN |=>
        input_current_sense_gain_out == ($past(reg_wr_data_in) & FOBS_MASK_IIN_GAIN))
        else $error("current sense gain write wrong");
    debounce_held_a: assert property (@(posedge mclk_in) disable iff (!rst_n_r)
        $rose(fast_ocp_trip_out) |-> $past(qual, 1) && $past(qual, 5) && $past(qual, 10))
        else $error("trip without held comparator");
    pwm_off_a: assert property (@(posedge mclk_in) disable iff (!rst_n_r)
        fast_ocp_trip_out |=> pwm_out == '0)
        else $error("pwm active during shutdown");
    cycle_resume_a: assert property (@(posedge mclk_in) disable iff (!rst_n_r)
        cycle_start_in && !trip_set |=> !fast_ocp_trip_out)
        else $error("shutdown not ended at cycle start");
    trip_hold_a: assert property (@(posedge mclk_in) disable iff (!rst_n_r)
        fast_ocp_trip_out && !cycle_start_in |=> fast_ocp_trip_out)
        else $error("shutdown ended inside the cycle");
    set_wins_a: assert property (@(posedge mclk_in) disable iff (!rst_n_r)
        trip_set |=> fast_ocp_trip_out && pwm_out == '0)
        else $error("trip not taken at once");
    deb_decode_a: assert property (@(posedge mclk_in) disable iff (!rst_n_r)
        timing_r.debounce == 2'h3 |-> deb_limit == 8'h3c)
        else $error("debounce 240 ns decode wrong");
    blank_mask_a: assert property (@(posedge mclk_in) disable iff (!rst_n_r)
        pwm_on_start_in && !fast_ocp_trip_out && !trip_set |=> !fast_ocp_trip_out [*8])
        else $error("trip during blanking");
    blank_decode_a: assert property (@(posedge mclk_in) disable iff (!rst_n_r)
        timing_r.blank == 3'h7 |-> blank_limit == 8'hc8)
        else $error("blanking 800 ns decode wrong");
    polarity_sel_a: assert property (@(posedge mclk_in) disable iff (!rst_n_r)
        current_limit_threshold_in[2] |=> cmp_act_r == $past(cs_over_neg_in))
        else $error("negative sensing not selected");
    blank_start_a: assert property (@(posedge mclk_in) disable iff (!rst_n_r)
        pwm_on_start_in |=> blanking [*8])
        else $error("blanking not started at on-time");

    trip_seen_c: cover property (@(posedge mclk_in) disable iff (!rst_n_r) $rose(fast_ocp_trip_out));
    resume_c: cover property (@(posedge mclk_in) disable iff (!rst_n_r) $fell(fast_ocp_trip_out));
    blank_hit_c: cover property (@(posedge mclk_in) disable iff (!rst_n_r) blanking && cmp_act_r);
    neg_trip_c: cover property (@(posedge mclk_in) disable iff (!rst_n_r)
        current_limit_threshold_in[2] && trip_set);
    set_wins_c: cover property (@(posedge mclk_in) disable iff (!rst_n_r) cycle_start_in && trip_set);
endmodule // fobs_fast_ocp

/* src/fobs_pkg.sv */
// package: register map, field layouts and timing constants of the fast overcurrent slice
package fobs_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [15:0] FOBS_ADDR_VIN_SCALE = 16'hfe3b;
    localparam logic [15:0] FOBS_ADDR_IIN_GAIN = 16'hfe3c;
    localparam logic [15:0] FOBS_ADDR_OCP_TIMING = 16'hfe3d;
    // writable bit masks, reserved bits read as zero
    localparam logic [15:0] FOBS_MASK_VIN_SCALE = 16'h3bff;
    localparam logic [15:0] FOBS_MASK_IIN_GAIN = 16'hfbff;
    localparam logic [15:0] FOBS_MASK_OCP_TIMING = 16'h001f;
    localparam logic [15:0] FOBS_RST_VIN_SCALE = 16'h0000;
    localparam logic [15:0] FOBS_RST_IIN_GAIN = 16'h0000;
    localparam logic [15:0] FOBS_RST_OCP_TIMING = 16'h0000;
    localparam logic [15:0] FOBS_RD_ZERO = 16'h0000;

    // ****************************************
    // field layouts
    // ****************************************
    typedef struct packed {
        logic [1:0] rsvd_hi;
        logic [2:0] exponent;
        logic rsvd_mid;
        logic [9:0] mantissa;
    } fobs_vin_scale_t;

    typedef struct packed {
        logic [4:0] exponent;
        logic rsvd_mid;
        logic [9:0] mantissa;
    } fobs_iin_gain_t;

    typedef struct packed {
        logic [10:0] rsvd_hi;
        logic [1:0] debounce;
        logic [2:0] blank;
    } fobs_ocp_timing_t;

    // ****************************************
    // timing
    // ****************************************
    localparam int FOBS_CLK_PERIOD_PS = 4000;
    localparam int FOBS_CNT_W = 8;
    localparam int FOBS_DEB_NS [4] = '{40, 80, 120, 240};
    localparam int FOBS_BLANK_NS [8] = '{40, 80, 120, 160, 200, 400, 600, 800};
    localparam logic [2:0] FOBS_THR_NEG_BIT = 3'h4;

    // least times round up to whole cycles, never below one
    function automatic logic [FOBS_CNT_W-1:0] fobs_ns_to_cyc(input int ns);
        int c;
        c = (ns * 1000 + FOBS_CLK_PERIOD_PS - 1) / FOBS_CLK_PERIOD_PS;
        if (c < 1) begin
            c = 1;
        end
        return c[FOBS_CNT_W-1:0];
    endfunction
endpackage

/* src/fobs_span_counter.sv */
// span counter: flags when a run of uncleared cycles reaches a limit
`timescale 1ns/1ps
module fobs_span_counter
    import fobs_pkg::*;
#(
    parameter int W = FOBS_CNT_W
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic clr_in,
    input wire logic [W-1:0] limit_in,
    output logic done_out
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;

    // saturate at the limit so a long run cannot wrap and drop the flag
    always_comb begin
        if (clr_in) begin
            cnt_nxt = '0;
        end else if (cnt_r >= limit_in) begin
            cnt_nxt = cnt_r;
        end else begin
            cnt_nxt = cnt_r + W'(1);
        end
    end

    // count state
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // done flag
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            done_out <= 1'b0;
        end else begin
            done_out <= !clr_in && (cnt_nxt >= limit_in);
        end
    end
endmodule // fobs_span_counter

/* sim/fobs_stage_model.sv */
// partner model: current-sense comparator and pwm generator beside the slice
`timescale 1ns/1ps
module fobs_stage_model
    import fobs_pkg::*;
#(
    parameter int PWM_N = 4
) (
    input wire logic clk_in,
    output logic cs_over_pos_out,
    output logic cs_over_neg_out,
    output logic on_start_out,
    output logic cycle_start_out,
    output logic [PWM_N-1:0] pwm_out
);
    // ****************************************
    // comparator and generator state
    // ****************************************
    logic [PWM_N-1:0] pat_r = '0;
    logic pos_r = 1'b0;
    logic neg_r = 1'b0;
    logic start_r = 1'b0;
    logic on_r = 1'b0;
    assign cs_over_pos_out = pos_r;
    assign cs_over_neg_out = neg_r;
    assign on_start_out = start_r || on_r;
    assign cycle_start_out = start_r;
    assign pwm_out = pat_r;
    // johnson pattern changes every cycle, so a stuck gate cannot hide
    always @(posedge clk_in) begin
        pat_r <= {pat_r[PWM_N-2:0], ~pat_r[PWM_N-1]};
    end
    // comparator levels move only at an edge, like a synchronous comparator
    task automatic sense(input logic pos, input logic neg);
        @(posedge clk_in);
        pos_r <= pos;
        neg_r <= neg;
    endtask
    // a switching cycle opens with its on-time, so both pulses coincide
    task automatic start();
        @(posedge clk_in);
        start_r <= 1'b1;
        @(posedge clk_in);
        start_r <= 1'b0;
    endtask
    // a lone on-time inside a cycle, so blanking and cycle end can be told apart
    task automatic on_time();
        @(posedge clk_in);
        on_r <= 1'b1;
        @(posedge clk_in);
        on_r <= 1'b0;
    endtask
endmodule // fobs_stage_model

/* sim/tb_fast_ocp_blank_and_scale_regs.sv */
// testbench: register map, blanking, debounce and shutdown of the fast overcurrent slice
`timescale 1ns/1ps
module tb_fast_ocp_blank_and_scale_regs
    import fobs_pkg::*;
;
    typedef struct {logic [15:0] a; logic [15:0] d; logic [15:0] e;} fobs_row_t;
    logic mclk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [15:0] reg_addr_in = 16'h0000;
    logic reg_wr_en_in = 1'b0;
    logic [15:0] reg_wr_data_in = 16'h0000;
    logic [2:0] current_limit_threshold_in = 3'h0;
    logic [15:0] reg_rd_data_out;
    logic cs_over_pos_in, cs_over_neg_in, pwm_on_start_in, cycle_start_in, fast_ocp_trip_out;
    logic [3:0] pwm_in, pwm_out, p;
    fobs_vin_scale_t vin;
    fobs_iin_gain_t iin;
    int n_mismatch = 0;
    int samples_checked = 0;
    int n;
    int deb_cyc [4] = '{10, 20, 30, 60}; // cycles at 4 ns
    int blk_cyc [8] = '{10, 20, 30, 40, 50, 100, 150, 200};
    // write data beside the read-back it should give; reserved bits drop
    fobs_row_t rows [9] = '{
        '{16'hfe3b, 16'hffff, 16'h3bff}, '{16'hfe3c, 16'hffff, 16'hfbff}, '{16'hfe3d, 16'hffff, 16'h001f},
        '{16'hfe3b, 16'h4400, 16'h0000}, '{16'hfe3c, 16'h0400, 16'h0000}, '{16'hfe3e, 16'hffff, 16'h0000},
        '{16'hfe3b, 16'h1a5c, 16'h1a5c}, '{16'hfe3c, 16'h8123, 16'h8123}, '{16'hfe3d, 16'h00e0, 16'h0000}
    };
    fobs_fast_ocp #(.PWM_N(4)) u_fobs_fast_ocp (
        .mclk_in, .rst_n_in, .reg_addr_in, .reg_wr_en_in, .reg_wr_data_in, .reg_rd_data_out,
        .current_limit_threshold_in, .cs_over_pos_in, .cs_over_neg_in, .pwm_on_start_in, .cycle_start_in,
        .pwm_in, .pwm_out, .fast_ocp_trip_out, .input_voltage_scale_out(vin), .input_current_sense_gain_out(iin)
    );
    fobs_stage_model #(.PWM_N(4)) u_fobs_stage_model (
        .clk_in(mclk_in), .cs_over_pos_out(cs_over_pos_in), .cs_over_neg_out(cs_over_neg_in),
        .on_start_out(pwm_on_start_in), .cycle_start_out(cycle_start_in), .pwm_out(pwm_in)
    );
    // ****************************************
    // helpers
    // ****************************************
    initial begin
        forever #2 mclk_in = ~mclk_in;
    end
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] s);
        samples_checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic close_out();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_wr_en_in <= 1'b1;
        reg_wr_data_in <= d;
        @(posedge mclk_in);
        reg_wr_en_in <= 1'b0;
    endtask
    // read data is registered, so wait two edges after the address settles
    task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
        @(posedge mclk_in);
        reg_addr_in <= a;
        repeat (2) @(posedge mclk_in);
        #1;
        chk("rd_data", e, reg_rd_data_out);
    endtask
    // counts edges until shutdown shows; bounded so a dead path cannot hang
    task automatic time_trip(output int cnt);
        cnt = 0;
        while (fast_ocp_trip_out !== 1'b1 && cnt < 400) begin
            @(posedge mclk_in);
            #1;
            cnt++;
        end
    endtask
    // program timing, open a fresh cycle and let its blanking run out
    task automatic arm(input logic [4:0] t, input logic [2:0] thr, input int settle);
        wr(16'hfe3d, {11'h000, t});
        current_limit_threshold_in <= thr;
        u_fobs_stage_model.sense(1'b0, 1'b0);
        u_fobs_stage_model.start();
        @(posedge mclk_in);
        #1;
        chk("trip_clear", 16'h0000, 16'(fast_ocp_trip_out));
        p = pwm_in;
        @(posedge mclk_in);
        #1;
        chk("pwm_follow", 16'(p), 16'(pwm_out));
        repeat (settle) @(posedge mclk_in);
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (20) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        repeat (4) @(posedge mclk_in);
        for (int i = 0; i < 3; i++) begin
            rd_chk(16'hfe3b + 16'(i), 16'h0000);
        end
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd_chk(rows[i].a, rows[i].e);
        end
        chk("vin_exp", 16'h0003, 16'(vin.exponent));
        chk("vin_mant", 16'h025c, 16'(vin.mantissa));
        chk("iin_exp", 16'h0010, 16'(iin.exponent));
        chk("iin_mant", 16'h0123, 16'(iin.mantissa));
        // a pulse lasting exactly the debounce time, a gap, then a longer one
        for (int d = 0; d < 4; d++) begin
            arm({d[1:0], 3'h0}, 3'h0, 14);
            u_fobs_stage_model.sense(1'b1, 1'b0);
            repeat (deb_cyc[d] - 1) @(posedge mclk_in);
            u_fobs_stage_model.sense(1'b0, 1'b0);
            u_fobs_stage_model.sense(1'b1, 1'b0);
            time_trip(n);
            chk("trip_delay", 16'(deb_cyc[d] + 2), 16'(n));
            u_fobs_stage_model.sense(1'b0, 1'b0);
            repeat (20) @(posedge mclk_in);
            for (int k = 0; k < 2; k++) begin
                @(posedge mclk_in);
                #1;
                chk("held_pwm", 16'h0000, 16'(pwm_out));
            end
            chk("held_trip", 16'h0001, 16'(fast_ocp_trip_out));
        end
        // comparator high across a new on-time: trip only after blanking plus debounce
        for (int b = 0; b < 8; b++) begin
            arm({2'h0, b[2:0]}, 3'h0, blk_cyc[b] + 4);
            u_fobs_stage_model.sense(1'b1, 1'b0);
            u_fobs_stage_model.on_time();
            time_trip(n);
            chk("blank_delay", 16'(blk_cyc[b] + 11), 16'(n));
        end
        // negative sensing ignores the positive comparator
        arm(5'h00, 3'h4, 14);
        u_fobs_stage_model.sense(1'b1, 1'b0);
        repeat (30) @(posedge mclk_in);
        #1;
        chk("pos_ignored", 16'h0000, 16'(fast_ocp_trip_out));
        u_fobs_stage_model.sense(1'b0, 1'b1);
        time_trip(n);
        chk("neg_delay", 16'h000c, 16'(n));
        // a trip in the cycle-start cycle wins; a lone on-time does not end shutdown
        u_fobs_stage_model.start();
        #1;
        chk("set_wins", 16'h0001, 16'(fast_ocp_trip_out));
        u_fobs_stage_model.on_time();
        #1;
        chk("on_time_hold", 16'h0001, 16'(fast_ocp_trip_out));
        // second reset in mid-run, while tripped
        @(posedge mclk_in);
        rst_n_in <= 1'b0;
        u_fobs_stage_model.sense(1'b0, 1'b0);
        @(posedge mclk_in);
        rst_n_in <= 1'b1;
        #1;
        chk("rst_trip", 16'h0000, 16'(fast_ocp_trip_out));
        chk("rst_pwm", 16'h0000, 16'(pwm_out));
        repeat (4) @(posedge mclk_in);
        rd_chk(16'hfe3b, 16'h0000);
        rd_chk(16'hfe3d, 16'h0000);
        close_out();
    end
    // watchdog: the run needs about 2000 cycles, 25000 means a hang
    initial begin
        #100000;
        n_mismatch++;
        close_out();
    end
endmodule // tb_fast_ocp_blank_and_scale_regs
